// ==== hw/lcc_regs.vh ====
// register map, field positions, reset values and timing counts of the charger control
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
`ifndef LCC_REGS_VH
`define LCC_REGS_VH

// byte offsets
`define LCC_CTRL_ADR       8'h00
`define LCC_ICHG_ADR       8'h04
`define LCC_VREG_ADR       8'h08
`define LCC_VPQ_ADR        8'h0C
`define LCC_TERMINATION_CURRENT_LEVEL_ADR      8'h10
`define LCC_RFH_ADR        8'h14
`define LCC_TOPOFF_ADR     8'h18
`define LCC_SAFE_ADR       8'h1C
`define LCC_JEITA_ADR      8'h20
`define LCC_STATUS_ADR     8'h24
`define LCC_ISTAT_ADR      8'h28
`define LCC_IMASK_ADR      8'h2C

// control fields
`define LCC_CTRL_EN        0
`define LCC_CTRL_AUTO      1
`define LCC_CTRL_STOP      2

// jeita fields
`define LCC_JT_COOL_V      0
`define LCC_JT_COOL_I      1
`define LCC_JT_WARM_V      2
`define LCC_JT_WARM_I      3

// interrupt fields
`define LCC_IRQ_DONE       0
`define LCC_IRQ_FAULT      1
`define LCC_IRQ_HOT        2
`define LCC_IRQ_STOP       3
`define LCC_IRQ_RECHG      4
`define LCC_IRQ_W          5

// reset values
`define LCC_ICHG_RST       4'h4
`define LCC_VREG_RST       10'h1A4
`define LCC_VPQ_RST        10'h12C
`define LCC_TERMINATION_CURRENT_LEVEL_RST      10'h014
`define LCC_RFH_RST        10'h00A
`define LCC_TOPOFF_RST     8'h1E
`define LCC_SAFE_RST       16'hC818
`define LCC_JEITA_RST      4'h5

// charge settings, current in 25 mA steps, voltage in 10 mV steps
`define LCC_I_MIN_STEPS    5'h02
`define LCC_I_MAX_STEPS    5'h1E
`define LCC_I_PQ_STEPS     5'h01
`define LCC_V_RED_STEPS    10'h00C

// zones
`define LCC_Z_COLD         3'h0
`define LCC_Z_COOL         3'h1
`define LCC_Z_NORM         3'h2
`define LCC_Z_WARM         3'h3
`define LCC_Z_HOT          3'h4

// one-second tick at 125 MHz
`define LCC_CLK_HZ         125_000_000
`define LCC_TICK_S         1
`define LCC_TICK_CYC       (`LCC_CLK_HZ * `LCC_TICK_S)

`endif

// ==== hw/lcc_sync.v ====
// two-flop synchroniser for a group of asynchronous level inputs
// assumes the inputs are quasi-static levels from comparators
`timescale 1ns/1ps
module lcc_sync #(
	parameter W = 5
) (
	// clock
	input  wire         clk,
	input  wire         rst,
	// levels
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	always @(posedge clk) begin
		if (rst) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule // lcc_sync

// ==== hw/lcc_tick.v ====
// divider making a one-cycle enable pulse every DIV clocks
// assumes one clock domain, synchronous reset
`timescale 1ns/1ps
module lcc_tick #(
	parameter [31:0] DIV = 32'd125_000_000
) (
	// clock
	input  wire clk,
	input  wire rst,
	// pulse
	output reg  tick
);
	reg [31:0] cnt_ff;

	always @(posedge clk) begin
		if (rst) begin
			cnt_ff <= 32'h0000_0000;
			tick   <= 1'b0;
		end else if (cnt_ff >= DIV - 32'd1) begin
			cnt_ff <= 32'h0000_0000;
			tick   <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 32'd1;
			tick   <= 1'b0;
		end
	end
endmodule // lcc_tick

// ==== hw/lcc_charger.v ====
// single-cell li-ion charge controller: mode sequencing, termination,
// recharge, temperature zones, safety timers, wishbone registers, interrupt
// assumes battery voltage and current samples arrive on CLK; the thermistor
// comparator levels are asynchronous
`timescale 1ns/1ps
`include "lcc_regs.vh"

// How it works
// - below prequal threshold, run prequalification
// - prequal current 25 mA, under 0.1C
// - fast charge drives CC/CV programmed setpoint
// - fast current 50 to 750 mA, 50 mA steps
// - host stop command halts charging
// - auto stop: termination current plus top-off expiry
// - auto stop: recharge below regulation minus hysteresis
// - disabled below 0 C or above 45 C
// - 10 to 25 C uses settings unchanged
// - cool and warm zones select reductions independently
// - reduction: minus 120 mV, half current
// - 60 C threshold raises an interrupt
// - safety timers bound prequal and fast charge
module lcc_charger #(
	parameter [31:0] TICK_CYC = `LCC_TICK_CYC
) (
	// clock and reset
	input  wire        CLK,
	input  wire        RST,
	// wishbone slave
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [7:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	// battery samples, 10 mV and 1 mA units
	input  wire [9:0]  BAT_MV,
	input  wire [9:0]  CHG_MA,
	// thermistor comparators, above 0/10/25/45/60 C
	input  wire [4:0]  THERMISTOR_INPUT,
	// charger power stage
	output reg         CHG_EN,
	output reg         CHG_PREQUAL,
	output reg  [4:0]  ISET_STEPS,
	output reg  [9:0]  VSET_STEPS,
	// interrupt
	output reg         IRQ
);
	localparam [2:0] ST_IDLE   = 3'd0;
	localparam [2:0] ST_PREQ   = 3'd1;
	localparam [2:0] ST_FAST   = 3'd2;
	localparam [2:0] ST_TOPOFF = 3'd3;
	localparam [2:0] ST_DONE   = 3'd4;
	localparam [2:0] ST_FAULT  = 3'd5;

	// configuration
	reg                  en_ff;
	reg                  auto_stop_enable_ff;
	reg [3:0]            ichg_ff;
	reg [9:0]            regulation_voltage_ff;
	reg [9:0]            prequal_threshold_ff;
	reg [9:0]            termination_current_level_ff;
	reg [9:0]            recharge_hysteresis_ff;
	reg [7:0]            top_off_duration_ff;
	reg [15:0]           safe_ff;
	reg [3:0]            jeita_ff;
	reg [`LCC_IRQ_W-1:0] istat_ff;
	reg [`LCC_IRQ_W-1:0] imask_ff;
	// state
	reg [2:0]            state_ff;
	reg [2:0]            nxt_state;
	reg [15:0]           sec_ff;
	reg                  hot_ff;
	wire [4:0]           thermistor_input;
	wire                 tick;

	lcc_sync #(
		.W (5)
	) u_sync (
		.clk (CLK),
		.rst (RST),
		.d   (THERMISTOR_INPUT),
		.q   (thermistor_input)
	);

	lcc_tick #(
		.DIV (TICK_CYC)
	) u_tick (
		.clk  (CLK),
		.rst  (RST),
		.tick (tick)
	);

	// temperature zone decode
	reg [2:0] zone;
	always @* begin
		if (!thermistor_input[0])
			zone = `LCC_Z_COLD;
		else if (!thermistor_input[1])
			zone = `LCC_Z_COOL;
		else if (!thermistor_input[2])
			zone = `LCC_Z_NORM;
		else if (!thermistor_input[3])
			zone = `LCC_Z_WARM;
		else
			zone = `LCC_Z_HOT;
	end

	wire temp_ok = (zone != `LCC_Z_COLD) && (zone != `LCC_Z_HOT);
	wire v_red = ((zone == `LCC_Z_COOL) && jeita_ff[`LCC_JT_COOL_V]) ||
		((zone == `LCC_Z_WARM) && jeita_ff[`LCC_JT_WARM_V]);
	wire i_red = ((zone == `LCC_Z_COOL) && jeita_ff[`LCC_JT_COOL_I]) ||
		((zone == `LCC_Z_WARM) && jeita_ff[`LCC_JT_WARM_I]);

	// effective setpoints; normal zone passes settings through
	wire [4:0] fast_raw = {ichg_ff, 1'b0};
	wire [4:0] fast_i = (fast_raw < `LCC_I_MIN_STEPS) ? `LCC_I_MIN_STEPS : fast_raw;
	wire [4:0] fast_half = {1'b0, fast_i[4:1]};
	wire [4:0] eff_i = i_red ? fast_half : fast_i;
	wire [9:0] vdrop = v_red ? `LCC_V_RED_STEPS : 10'h000;
	wire [9:0] eff_v = (regulation_voltage_ff > vdrop) ?
		(regulation_voltage_ff - vdrop) : 10'h000;

	// comparisons
	wire        below_pq = BAT_MV < prequal_threshold_ff;
	wire        at_termination_current_level = CHG_MA <= termination_current_level_ff;
	wire [10:0] rech_sum = {1'b0, BAT_MV} + {1'b0, recharge_hysteresis_ff};
	wire        need_rech = rech_sum < {1'b0, eff_v};
	wire        top_done = sec_ff >= {8'h00, top_off_duration_ff};
	wire        pq_over = (safe_ff[7:0] != 8'h00) && (sec_ff[13:6] >= safe_ff[7:0]);
	wire        fc_over = (safe_ff[15:8] != 8'h00) && (sec_ff[13:6] >= safe_ff[15:8]);

	// bus decode
	wire        req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire        wr = req && WB_WE_I;
	wire        wr_ctrl = wr && (WB_ADR_I == `LCC_CTRL_ADR) && WB_SEL_I[0];
	wire        stop_cmd = wr_ctrl && WB_DAT_I[`LCC_CTRL_STOP];
	wire        en_next = stop_cmd ? 1'b0 : (wr_ctrl ? WB_DAT_I[`LCC_CTRL_EN] : en_ff);

	// mode sequencing
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (en_ff && temp_ok)
					nxt_state = below_pq ? ST_PREQ : ST_FAST;
			end
			ST_PREQ: begin
				if (pq_over)
					nxt_state = ST_FAULT;
				else if (!below_pq)
					nxt_state = ST_FAST;
			end
			ST_FAST: begin
				if (fc_over)
					nxt_state = ST_FAULT;
				else if (below_pq)
					nxt_state = ST_PREQ;
				else if (auto_stop_enable_ff && at_termination_current_level)
					nxt_state = ST_TOPOFF;
			end
			ST_TOPOFF: begin
				if (!auto_stop_enable_ff || !at_termination_current_level)
					nxt_state = ST_FAST;
				else if (top_done)
					nxt_state = ST_DONE;
			end
			ST_DONE: begin
				if (!auto_stop_enable_ff)
					nxt_state = ST_IDLE;
				else if (need_rech)
					nxt_state = ST_FAST;
			end
			ST_FAULT: begin
				nxt_state = ST_FAULT;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (state_ff != ST_FAULT && state_ff != ST_DONE && !temp_ok)
			nxt_state = ST_IDLE;
		// done holds through a temperature excursion, but never past a stop
		if (state_ff == ST_DONE && auto_stop_enable_ff && !temp_ok)
			nxt_state = ST_DONE;
		if (!en_ff || stop_cmd)
			nxt_state = ST_IDLE;
	end

	wire ev_done = (state_ff == ST_TOPOFF) && (nxt_state == ST_DONE);
	wire ev_fault = (state_ff != ST_FAULT) && (nxt_state == ST_FAULT);
	wire ev_hot = thermistor_input[4] && !hot_ff;
	wire ev_rech = (state_ff == ST_DONE) && (nxt_state == ST_FAST);
	wire [`LCC_IRQ_W-1:0] ev = {ev_rech, stop_cmd, ev_hot, ev_fault, ev_done};
	wire charging = (state_ff == ST_PREQ) || (state_ff == ST_FAST) ||
		(state_ff == ST_TOPOFF);

	// state, timer, outputs
	always @(posedge CLK) begin
		if (RST) begin
			state_ff    <= ST_IDLE;
			sec_ff      <= 16'h0000;
			hot_ff      <= 1'b0;
			CHG_EN      <= 1'b0;
			CHG_PREQUAL <= 1'b0;
			ISET_STEPS  <= 5'h00;
			VSET_STEPS  <= 10'h000;
			IRQ         <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			hot_ff   <= thermistor_input[4];
			if (nxt_state != state_ff)
				sec_ff <= 16'h0000;
			else if (tick && sec_ff != 16'hFFFF)
				sec_ff <= sec_ff + 16'h0001;
			CHG_EN      <= charging && temp_ok;
			CHG_PREQUAL <= state_ff == ST_PREQ;
			ISET_STEPS  <= (state_ff == ST_PREQ) ? `LCC_I_PQ_STEPS : eff_i;
			VSET_STEPS  <= eff_v;
			IRQ         <= |(istat_ff & imask_ff);
		end
	end

	// register writes
	always @(posedge CLK) begin
		if (RST) begin
			en_ff                        <= 1'b0;
			auto_stop_enable_ff          <= 1'b0;
			ichg_ff                      <= `LCC_ICHG_RST;
			regulation_voltage_ff        <= `LCC_VREG_RST;
			prequal_threshold_ff         <= `LCC_VPQ_RST;
			termination_current_level_ff <= `LCC_TERMINATION_CURRENT_LEVEL_RST;
			recharge_hysteresis_ff       <= `LCC_RFH_RST;
			top_off_duration_ff          <= `LCC_TOPOFF_RST;
			safe_ff                      <= `LCC_SAFE_RST;
			jeita_ff                     <= `LCC_JEITA_RST;
			istat_ff                     <= {`LCC_IRQ_W{1'b0}};
			imask_ff                     <= {`LCC_IRQ_W{1'b0}};
		end else begin
			en_ff <= en_next;
			if (wr_ctrl)
				auto_stop_enable_ff <= WB_DAT_I[`LCC_CTRL_AUTO];
			if (wr && WB_SEL_I[0]) begin
				case (WB_ADR_I)
					`LCC_ICHG_ADR: ichg_ff <= WB_DAT_I[3:0];
					`LCC_TOPOFF_ADR: top_off_duration_ff <= WB_DAT_I[7:0];
					`LCC_JEITA_ADR: jeita_ff <= WB_DAT_I[3:0];
					`LCC_IMASK_ADR: imask_ff <= WB_DAT_I[`LCC_IRQ_W-1:0];
					default: begin
					end
				endcase
			end
			if (wr && WB_SEL_I[0] && WB_SEL_I[1]) begin
				case (WB_ADR_I)
					`LCC_VREG_ADR: regulation_voltage_ff <= WB_DAT_I[9:0];
					`LCC_VPQ_ADR: prequal_threshold_ff <= WB_DAT_I[9:0];
					`LCC_TERMINATION_CURRENT_LEVEL_ADR: termination_current_level_ff <= WB_DAT_I[9:0];
					`LCC_RFH_ADR: recharge_hysteresis_ff <= WB_DAT_I[9:0];
					`LCC_SAFE_ADR: safe_ff <= WB_DAT_I[15:0];
					default: begin
					end
				endcase
			end
			// new events win over a simultaneous clear
			if (wr && WB_SEL_I[0] && WB_ADR_I == `LCC_ISTAT_ADR)
				istat_ff <= (istat_ff & ~WB_DAT_I[`LCC_IRQ_W-1:0]) | ev;
			else
				istat_ff <= istat_ff | ev;
		end
	end

	// read mux
	reg [31:0] rd;
	always @* begin
		rd = 32'h0000_0000;
		case (WB_ADR_I)
			`LCC_CTRL_ADR: rd = {30'h0000_0000, auto_stop_enable_ff, en_ff};
			`LCC_ICHG_ADR: rd = {28'h000_0000, ichg_ff};
			`LCC_VREG_ADR: rd = {22'h00_0000, regulation_voltage_ff};
			`LCC_VPQ_ADR: rd = {22'h00_0000, prequal_threshold_ff};
			`LCC_TERMINATION_CURRENT_LEVEL_ADR: rd = {22'h00_0000, termination_current_level_ff};
			`LCC_RFH_ADR: rd = {22'h00_0000, recharge_hysteresis_ff};
			`LCC_TOPOFF_ADR: rd = {24'h00_0000, top_off_duration_ff};
			`LCC_SAFE_ADR: rd = {16'h0000, safe_ff};
			`LCC_JEITA_ADR: rd = {28'h000_0000, jeita_ff};
			`LCC_STATUS_ADR: rd = {20'h0_0000, thermistor_input, zone, 1'b0, state_ff};
			`LCC_ISTAT_ADR: rd = {27'h000_0000, istat_ff};
			`LCC_IMASK_ADR: rd = {27'h000_0000, imask_ff};
			default: rd = 32'h0000_0000;
		endcase
	end

	// single-wait-state ack
	always @(posedge CLK) begin
		if (RST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= req;
			if (req && !WB_WE_I)
				WB_DAT_O <= rd;
		end
	end
endmodule // lcc_charger

// ==== dv/lcc_properties.sv ====
// port assertions for the charge controller, bound into lcc_charger
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module lcc_properties (
	// clock and reset
	input wire        CLK,
	input wire        RST,
	// bus
	input wire        WB_CYC_I,
	input wire        WB_STB_I,
	input wire        WB_WE_I,
	input wire [7:0]  WB_ADR_I,
	input wire [31:0] WB_DAT_O,
	input wire        WB_ACK_O,
	// charger
	input wire [4:0]  THERMISTOR_INPUT,
	input wire        CHG_EN,
	input wire        CHG_PREQUAL,
	input wire [4:0]  ISET_STEPS
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);
	wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

	ack_answer_a: assert property (req |=> WB_ACK_O)
		else $error("request not acked next cycle");
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	rd_unmapped_a: assert property (req && !WB_WE_I && WB_ADR_I > 8'h2C |=> WB_DAT_O == 0)
		else $error("unmapped read not zero");
	pq_enabled_a: assert property (CHG_PREQUAL |-> CHG_EN)
		else $error("prequal without power stage");
	pq_current_a: assert property (CHG_PREQUAL |-> ISET_STEPS == 5'h01)
		else $error("prequal current not one step");
	fast_range_a: assert property (CHG_EN && !CHG_PREQUAL |-> ISET_STEPS inside {[1:30]})
		else $error("fast current out of range");
	cold_off_a: assert property (!THERMISTOR_INPUT[0] [*5] |=> !CHG_EN)
		else $error("charging below lowest boundary");
	hot_off_a: assert property (THERMISTOR_INPUT[3] [*5] |=> !CHG_EN)
		else $error("charging above upper boundary");
endmodule // lcc_properties

bind lcc_charger lcc_properties u_props (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .THERMISTOR_INPUT(THERMISTOR_INPUT), .CHG_EN(CHG_EN),
	.CHG_PREQUAL(CHG_PREQUAL), .ISET_STEPS(ISET_STEPS));

// ==== dv/lcc_battery.sv ====
// battery model: reports cell voltage and the current drawn
// assumes set points from the bench, samples on the charger clock
`timescale 1ns/1ps
module lcc_battery (
	input  wire       clk,
	input  wire       chg_en,
	input  wire [9:0] mv_set,
	input  wire [9:0] ma_set,
	output reg  [9:0] bat_mv = 10'h000,
	output reg  [9:0] chg_ma = 10'h000
);
	// current flows only while the power stage is on
	always @(posedge clk) begin
		bat_mv <= mv_set;
		chg_ma <= chg_en ? ma_set : 10'h000;
	end
endmodule // lcc_battery

// ==== dv/tb.sv ====
// self-checking bench for the charge controller
// assumes lcc_battery on the power side, host on wishbone
`timescale 1ns/1ps
`include "lcc_regs.vh"
module tb;
	reg          CLK = 0, RST = 1, cyc = 0, stb = 0, we = 0;
	reg  [7:0]   adr = 8'h00;
	reg  [31:0]  wdat = 32'h0000_0000;
	reg  [4:0]   thermistor_input = 5'h03;
	reg  [9:0]   mv = 10'h100, ma = 10'h064, bmv, bma;
	reg  [15:0]  lfsr = 16'd59778;
	wire [31:0]  rdat;
	wire         ack, en, pq, irq;
	wire [4:0]   iset;
	wire [9:0]   vset;
	logic [31:0] expq[$];
	logic [31:0] rv [0:12] = '{0, `LCC_ICHG_RST, `LCC_VREG_RST, `LCC_VPQ_RST,
		`LCC_TERMINATION_CURRENT_LEVEL_RST, `LCC_RFH_RST, `LCC_TOPOFF_RST, `LCC_SAFE_RST, `LCC_JEITA_RST, 0, 0, 0, 0};
	logic [3:0]  jc;
	logic [4:0]  f;
	integer      error_cnt = 0, total_checks = 0, i, b, w;
	always #4 CLK = ~CLK;

	lcc_battery bat (.clk(CLK), .chg_en(en), .mv_set(mv), .ma_set(ma), .bat_mv(bmv),
		.chg_ma(bma));
	lcc_charger #(.TICK_CYC(32'd10)) dut (.CLK(CLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .BAT_MV(bmv), .CHG_MA(bma), .THERMISTOR_INPUT(thermistor_input), .CHG_EN(en),
		.CHG_PREQUAL(pq), .ISET_STEPS(iset), .VSET_STEPS(vset), .IRQ(irq));

	function [15:0] nxt_rand(input [15:0] s);
		nxt_rand = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input string nm, input [31:0] e, input [31:0] g);
		total_checks++;
		if (e !== g) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wb(input w_, input [7:0] a, input [31:0] d);
		integer n;
		cyc <= 1;
		stb <= 1;
		we <= w_;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin @(posedge CLK); n++; end while (ack !== 1'b1 && n < 20);
		if (n >= 20) chk("ack", 1, 0);
		cyc <= 0;
		stb <= 0;
		@(posedge CLK);
	endtask
	task wr(input [7:0] a, input [31:0] d); wb(1, a, d); endtask
	task rd(input [7:0] a, input [31:0] e); expq.push_back(e); wb(0, a, 0); endtask
	task tk(input integer n); repeat (n) @(posedge CLK); endtask
	task fall(input integer lim); i = 0;
		while (en !== 1'b0 && i < lim) begin @(posedge CLK); i++; end
	endtask
	// read data compared at the ack edge
	always @(posedge CLK)
		if (ack === 1'b1 && !we && expq.size() != 0)
			chk("read data", expq.pop_front(), rdat);

	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		error_cnt++;
		complete_run;
	end

	initial begin
		tk(5);
		RST <= 0;
		for (int k = 0; k < 13; k++)
			if (k != 9) rd(8'(k * 4), rv[k]);
		$display("reset values done");
		wr(`LCC_CTRL_ADR, 32'h0000_0003);
		tk(4);
		chk("prequal", 3'b111, {en, pq, iset == 5'h01});
		mv <= 10'h180;
		for (i = 0; i < 16; i++) begin
			wr(`LCC_ICHG_ADR, i);
			tk(2);
			chk("fast iset", {1'b1, 5'(i < 2 ? 2 : 2 * i)}, {en & ~pq, iset});
		end
		chk("vset", `LCC_VREG_RST, vset);
		lfsr = nxt_rand(lfsr);
		jc = lfsr[3:0];
		f = jc < 2 ? 5'h02 : {jc, 1'b0};
		wr(`LCC_ICHG_ADR, jc);
		for (i = 0; i < 8; i++) begin
			b = i % 4;
			w = i / 4;
			wr(`LCC_JEITA_ADR, 1 << b);
			thermistor_input <= w ? 5'h07 : 5'h01;
			tk(8);
			chk("zone set", {b == 2 * w + 1 ? f >> 1 : f, `LCC_VREG_RST - (b == 2 * w ?
				`LCC_V_RED_STEPS : 10'h000)}, {iset, vset});
		end
		for (i = 0; i < 2; i++) begin
			thermistor_input <= i ? 5'h0F : 5'h00;
			tk(8);
			chk("temp off", 0, en);
			thermistor_input <= 5'h03;
			tk(8);
			chk("temp resume", {1'b1, f, `LCC_VREG_RST}, {en, iset, vset});
		end
		$display("zones done");
		wr(`LCC_IMASK_ADR, 32'h0000_0004);
		thermistor_input <= 5'h1F;
		tk(8);
		chk("irq hot", 1, irq);
		rd(`LCC_ISTAT_ADR, 32'h0000_0004);
		wr(`LCC_IMASK_ADR, 32'h0000_0000);
		chk("irq masked", 0, irq);
		wr(`LCC_IMASK_ADR, 32'h0000_0004);
		chk("irq unmasked", 1, irq);
		wr(`LCC_ISTAT_ADR, 32'h0000_0004);
		chk("irq cleared", 0, irq);
		thermistor_input <= 5'h03;
		mv <= 10'h1A4;
		ma <= 10'h00A;
		wr(`LCC_TOPOFF_ADR, 32'h0000_0004);
		tk(8);
		fall(200);
		chk("top off time", 1, i >= 10 && i < 200);
		rd(`LCC_STATUS_ADR, 32'h0000_01A4);
		rd(`LCC_ISTAT_ADR, 32'h0000_0001);
		ma <= 10'h064;
		mv <= 10'h19A;
		tk(8);
		chk("no recharge", 0, en);
		mv <= 10'h199;
		tk(8);
		chk("recharge", 1, en);
		rd(`LCC_ISTAT_ADR, 32'h0000_0011);
		wr(`LCC_ISTAT_ADR, 32'h0000_001F);
		$display("termination done");
		wr(`LCC_CTRL_ADR, 32'h0000_0007);
		tk(4);
		chk("stop", 0, en);
		rd(`LCC_CTRL_ADR, 32'h0000_0002);
		rd(`LCC_ISTAT_ADR, 32'h0000_0008);
		wr(`LCC_ISTAT_ADR, 32'h0000_001F);
		wr(`LCC_SAFE_ADR, 32'h0000_0001);
		mv <= 10'h100;
		wr(`LCC_CTRL_ADR, 32'h0000_0001);
		tk(4);
		chk("prequal again", 1, en & pq);
		fall(1500);
		chk("safety time", 1, i > 600 && i < 1500);
		rd(`LCC_ISTAT_ADR, 32'h0000_0002);
		$display("stop and safety done");
		complete_run;
	end
endmodule // tb
